// ### address_break.sv
// Purpose: address break comparator with Avalon-MM register slave
// Assumes: cpu bus cycle and instruction pulses are synchronous to clk
// Notes:   registers answer with waitrequest low one cycle after request
//
// Operation
// - clear bit masks interrupts one instruction after return
// - cycle select picks fetch, read, write, both
// - address compare 000 uses all 24 bits
// - 001/010/011 compare upper 20/16/12 bits
// - data compare 00 disables data check
// - 01 low byte, 10 high, 11 word
// - data lane follows access size and address
// - 8-bit i/o word access uses upper lane
// - matching cycle sets break flag
// - flag clears on zero write after reading one
// - enable bit gates break interrupt request
// - low six status bits read as one
// - 24-bit break address resets to all ones
// - request ignores cpu mask, taken after instruction
// - high byte upper lane, low byte lower
`timescale 1ns/100ps
`default_nettype none
module address_break (
    // clock and reset
    input  wire logic                                clk,
    input  wire logic                                sys_rst,
    // avalon-mm register slave
    input  wire logic [address_break_pkg::REG_IDX_W-1:0] avsAddress,
    input  wire logic                                avsRead,
    input  wire logic                                avsWrite,
    input  wire logic [31:0]                         avsWriteData,
    input  wire logic [3:0]                          avsByteEnable,
    output logic      [31:0]                         avsReadData,
    output logic                                     avsWaitRequest,
    // watched cpu bus cycle
    input  wire address_break_pkg::cycle_kind_t      cpuCycleKind,
    input  wire address_break_pkg::space_t           cpuSpace,
    input  wire logic                                cpuWordAccess,
    input  wire logic [address_break_pkg::ADDR_W-1:0] cpuAddr,
    input  wire logic [address_break_pkg::DATA_W-1:0] cpuData,
    // instruction progress
    input  wire logic                                cpuRetDone,
    input  wire logic                                cpuInstrDone,
    // requests to the cpu
    output logic                                     breakIrq,
    output logic                                     retIrqMask,
    output logic                                     irqOut
);
    import address_break_pkg::*;

    typedef struct packed {
        logic [7:0]  control;
        logic        flag;
        logic        enable;
        logic [23:0] addr;
        logic [15:0] data;
        logic        readArm;
        logic [1:0]  intStatus;
        logic [1:0]  intMask;
        logic        retMask;
        logic        breakIrq;
        logic        irqOut;
        bus_phase_t  phase;
        logic        waitReq;
        logic [31:0] readData;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic        hit;
    logic        req;
    logic        commit;
    logic        wrCommit;
    logic        rdCommit;
    logic [31:0] wdata;
    logic [31:0] rdValue;
    logic [7:0]  statusView;

    break_match_if mIf ();

    // settings and watched cycle go to the comparator
    assign mIf.clk        = clk;
    assign mIf.rst        = sys_rst;
    assign mIf.cycleSel   = st_q.control[CYCLE_SEL_LSB +: 2];
    assign mIf.addrSel    = st_q.control[ADDR_CMP_LSB +: 3];
    assign mIf.dataSel    = st_q.control[DATA_CMP_LSB +: 2];
    assign mIf.matchAddr  = st_q.addr;
    assign mIf.matchData  = st_q.data;
    assign mIf.kind       = cpuCycleKind;
    assign mIf.space      = cpuSpace;
    assign mIf.wordAccess = cpuWordAccess;
    assign mIf.busAddr    = cpuAddr;
    assign mIf.busData    = cpuData;
    assign hit            = mIf.hit;

    break_matcher u_matcher (
        .m (mIf.cmp)
    );

    // a request commits only in the cycle waitrequest is seen low
    assign req      = avsRead || avsWrite;
    assign commit   = req && (st_q.phase == PH_ANSWER);
    assign wrCommit = commit && avsWrite;
    assign rdCommit = commit && avsRead;

    // byte enables keep the old contents of lanes not written
    always_comb begin
        wdata = rdValue;
        for (int i = 0; i < 4; i++) begin
            if (avsByteEnable[i]) begin
                wdata[8*i +: 8] = avsWriteData[8*i +: 8];
            end
        end
    end

    assign statusView = {st_q.flag, st_q.enable, STATUS_RESERVED};

    // read view of the addressed register; unmapped words read zero
    always_comb begin
        case (avsAddress)
            OFS_CONTROL:    rdValue = {24'h000000, st_q.control};
            OFS_STATUS:     rdValue = {24'h000000, statusView};
            OFS_ADDRESS:    rdValue = {8'h00, st_q.addr};
            OFS_DATA:       rdValue = {16'h0000, st_q.data};
            OFS_INT_STATUS: rdValue = {30'h0, st_q.intStatus};
            OFS_INT_MASK:   rdValue = {30'h0, st_q.intMask};
            default:        rdValue = 32'h00000000;
        endcase
    end

    // next state of the whole block
    always_comb begin
        st_d = st_q;

        // bus handshake: one wait cycle, then one answer cycle
        case (st_q.phase)
            PH_WAIT: begin
                if (req) begin
                    st_d.phase    = PH_ANSWER;
                    st_d.waitReq  = 1'b0;
                    st_d.readData = avsRead ? rdValue : 32'h00000000;
                end
            end
            PH_ANSWER: begin
                st_d.phase   = PH_WAIT;
                st_d.waitReq = 1'b1;
            end
            default: begin
                st_d.phase   = PH_WAIT;
                st_d.waitReq = 1'b1;
            end
        endcase

        // register writes; read-only and reserved bits are not stored
        if (wrCommit) begin
            case (avsAddress)
                OFS_CONTROL: st_d.control = wdata[7:0];
                OFS_STATUS:  st_d.enable  = wdata[ENABLE_BIT];
                OFS_ADDRESS: st_d.addr    = wdata[23:0];
                OFS_DATA:    st_d.data    = wdata[15:0];
                OFS_INT_STATUS: begin
                    // write one to clear
                    st_d.intStatus = st_q.intStatus & ~avsWriteData[1:0];
                end
                OFS_INT_MASK: st_d.intMask = wdata[1:0];
                default: begin
                end
            endcase
        end

        // arm the flag clear only after a read that returned it as one
        if (rdCommit && avsAddress == OFS_STATUS) begin
            st_d.readArm = st_q.readData[FLAG_BIT];
        end
        if (wrCommit && avsAddress == OFS_STATUS) begin
            st_d.readArm = 1'b0;
            if (st_q.readArm && avsByteEnable[0]
                && !avsWriteData[FLAG_BIT]) begin
                st_d.flag = 1'b0;
            end
        end

        // a match in the same cycle as a clear keeps the flag set
        if (hit) begin
            st_d.flag = 1'b1;
            st_d.intStatus[INT_BREAK_BIT] = 1'b1;
        end

        // one-instruction mask after return; a new return restarts it
        if (st_q.retMask && cpuInstrDone) begin
            st_d.retMask = 1'b0;
        end
        if (cpuRetDone && !st_q.control[RET_INT_EN_BIT]) begin
            st_d.retMask = 1'b1;
            st_d.intStatus[INT_RET_BIT] = 1'b1;
        end

        // request bypasses the cpu mask bit; cpu takes it after the
        // current instruction, so only the level is kept here
        st_d.breakIrq = st_d.flag && st_d.enable
                      && !st_d.retMask;
        st_d.irqOut   = |(st_d.intStatus & st_d.intMask);
    end

    // single state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q.control   <= CONTROL_RESET;
            st_q.flag      <= 1'b0;
            st_q.enable    <= 1'b0;
            st_q.addr      <= ADDRESS_RESET;
            st_q.data      <= DATA_RESET;
            st_q.readArm   <= 1'b0;
            st_q.intStatus <= 2'h0;
            st_q.intMask   <= 2'h0;
            st_q.retMask   <= 1'b0;
            st_q.breakIrq  <= 1'b0;
            st_q.irqOut    <= 1'b0;
            st_q.phase     <= PH_WAIT;
            st_q.waitReq   <= 1'b1;
            st_q.readData  <= 32'h00000000;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign avsReadData    = st_q.readData;
    assign avsWaitRequest = st_q.waitReq;
    assign breakIrq       = st_q.breakIrq;
    assign retIrqMask     = st_q.retMask;
    assign irqOut         = st_q.irqOut;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence retNoReturnEnable;
        cpuRetDone && !st_q.control[RET_INT_EN_BIT];
    endsequence
    sequence statusReadOne;
        rdCommit && avsAddress == OFS_STATUS && st_q.readData[FLAG_BIT];
    endsequence
    sequence clearWrite;
        wrCommit && avsAddress == OFS_STATUS && avsByteEnable[0]
        && !avsWriteData[FLAG_BIT] && !hit;
    endsequence

    hit_sets_flag_a: assert property (hit |=> st_q.flag)
        else $error("match did not set break flag");
    flag_clear_cause_a: assert property ($fell(st_q.flag)
        |-> $past(st_q.readArm) && $past(wrCommit))
        else $error("break flag cleared without read of one");
    read_then_clear_a: assert property (statusReadOne ##[1:8] clearWrite
        |=> !st_q.flag)
        else $error("break flag not cleared after read and write");
    irq_gated_a: assert property (breakIrq
        |-> st_q.flag && st_q.enable && !retIrqMask)
        else $error("break request without flag and enable");
    irq_follows_a: assert property ((st_q.flag && st_q.enable
        && !retIrqMask)[*2] |-> breakIrq)
        else $error("break request missing");
    reserved_ones_a: assert property ((req && st_q.phase == PH_WAIT
        && avsRead && avsAddress == OFS_STATUS)
        |=> avsReadData[5:0] == STATUS_RESERVED)
        else $error("reserved status bits not read as one");
    ret_mask_a: assert property (retNoReturnEnable |=> retIrqMask
        ##0 (retIrqMask throughout (!cpuInstrDone)[*1])
        or (retIrqMask && cpuInstrDone))
        else $error("return mask not raised");
    ret_unmask_a: assert property ((retIrqMask && cpuInstrDone
        && !cpuRetDone) |=> !retIrqMask)
        else $error("return mask held past one instruction");
    reset_values_a: assert property ($past(sys_rst) |-> st_q.addr
        == ADDRESS_RESET && st_q.control == CONTROL_RESET)
        else $error("wrong reset values");
    answer_timing_a: assert property ((req && avsWaitRequest)
        |=> !avsWaitRequest ##1 avsWaitRequest)
        else $error("answer not after one wait cycle");
endmodule : address_break
`default_nettype wire

// ### address_break_pkg.sv
// Purpose: shared constants and types for the address break comparator
// Assumes: 32-bit Avalon-MM slave, one register per aligned word
// Notes:   word offsets below are register indices, byte address is 4x
`default_nettype none
package address_break_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int REG_IDX_W = 3;

    // register word indices
    localparam logic [2:0] OFS_CONTROL    = 3'h0;
    localparam logic [2:0] OFS_STATUS     = 3'h1;
    localparam logic [2:0] OFS_ADDRESS    = 3'h2;
    localparam logic [2:0] OFS_DATA       = 3'h3;
    localparam logic [2:0] OFS_INT_STATUS = 3'h4;
    localparam logic [2:0] OFS_INT_MASK   = 3'h5;

    // break_condition_control field positions
    localparam int RET_INT_EN_BIT = 7;
    localparam int CYCLE_SEL_LSB  = 5;
    localparam int ADDR_CMP_LSB   = 2;
    localparam int DATA_CMP_LSB   = 0;
    // break_status_enable field positions
    localparam int FLAG_BIT       = 7;
    localparam int ENABLE_BIT     = 6;
    // interrupt status / mask bit positions
    localparam int INT_BREAK_BIT  = 0;
    localparam int INT_RET_BIT    = 1;

    // reset values and the read value of the reserved status bits
    localparam logic [7:0]  CONTROL_RESET   = 8'h80;
    localparam logic [5:0]  STATUS_RESERVED = 6'h3f;
    localparam logic [23:0] ADDRESS_RESET   = 24'hffffff;
    localparam logic [15:0] DATA_RESET      = 16'h0000;

    // cycle-select codes
    localparam logic [1:0] SEL_FETCH = 2'h0;
    localparam logic [1:0] SEL_READ  = 2'h1;
    localparam logic [1:0] SEL_WRITE = 2'h2;
    localparam logic [1:0] SEL_RDWR  = 2'h3;
    // address-compare codes
    localparam logic [2:0] ACMP_24 = 3'h0;
    localparam logic [2:0] ACMP_20 = 3'h1;
    localparam logic [2:0] ACMP_16 = 3'h2;
    localparam logic [2:0] ACMP_12 = 3'h3;
    // data-compare codes
    localparam logic [1:0] DCMP_NONE = 2'h0;
    localparam logic [1:0] DCMP_LOW  = 2'h1;
    localparam logic [1:0] DCMP_HIGH = 2'h2;
    localparam logic [1:0] DCMP_FULL = 2'h3;

    typedef enum logic [1:0] {CYC_IDLE, CYC_FETCH, CYC_READ, CYC_WRITE}
        cycle_kind_t;
    typedef enum logic [1:0] {SPACE_ROM, SPACE_RAM, SPACE_IO8, SPACE_IO16}
        space_t;
    typedef enum logic {PH_WAIT, PH_ANSWER} bus_phase_t;
endpackage : address_break_pkg
`default_nettype wire

// ### address_break_test.sv
// Purpose: self-checking bench for the address break comparator
// Assumes: avalon master waits for waitrequest low, bounded by a timeout
// Notes:   break address is fixed once and reused by every scenario
`timescale 1ns/100ps
`default_nettype none
module address_break_test;
    import address_break_pkg::*;
    localparam logic [23:0] TGT = 24'h123456;
    logic        clk;
    logic        sys_rst;
    logic [2:0]  avsAddress;
    logic        avsRead;
    logic        avsWrite;
    logic [31:0] avsWriteData;
    logic [3:0]  avsByteEnable;
    logic [31:0] avsReadData;
    logic        avsWaitRequest;
    cycle_kind_t cpuCycleKind;
    space_t      cpuSpace;
    logic        cpuWordAccess;
    logic [23:0] cpuAddr;
    logic [15:0] cpuData;
    logic        cpuRetDone;
    logic        cpuInstrDone;
    logic        breakIrq;
    logic        retIrqMask;
    logic        irqOut;
    int          failCount;
    int          numChecks;

    address_break dut_u (.clk(clk), .sys_rst(sys_rst),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .cpuCycleKind(cpuCycleKind), .cpuSpace(cpuSpace),
        .cpuWordAccess(cpuWordAccess), .cpuAddr(cpuAddr),
        .cpuData(cpuData), .cpuRetDone(cpuRetDone),
        .cpuInstrDone(cpuInstrDone), .breakIrq(breakIrq),
        .retIrqMask(retIrqMask), .irqOut(irqOut));

    cpu_core_model cpu_u (.clk(clk), .cycleKind(cpuCycleKind),
        .space(cpuSpace), .wordAccess(cpuWordAccess), .addr(cpuAddr),
        .data(cpuData), .retDone(cpuRetDone), .instrDone(cpuInstrDone));

    // free-running 100 MHz clock
    always #5 clk = ~clk;

    task automatic final_report;
        if (failCount == 0 && numChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit

    // one avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [2:0] idx,
                       input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avsAddress    <= idx;
        avsWrite      <= wr;
        avsRead       <= !wr;
        avsWriteData  <= wd;
        avsByteEnable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 20);
        rd = avsReadData;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
        if (n >= 20) begin
            failCount++;
            final_report();
        end
    endtask : bus

    task automatic wr_reg(input logic [2:0] idx, input logic [31:0] wd,
                          input logic [3:0] be);
        logic [31:0] rd;
        bus(1'b1, idx, wd, be, rd);
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] idx, output logic [31:0] rd);
        bus(1'b0, idx, 32'h0, 4'hf, rd);
    endtask : rd_reg

    // one watched access, then flag read and read-then-write clear
    task automatic try_hit(input cycle_kind_t k, input space_t s,
                           input logic w, input logic [23:0] a,
                           input logic [15:0] d, input logic exp);
        logic [31:0] rd;
        cpu_u.issue(k, s, w, a, d);
        rd_reg(OFS_STATUS, rd);
        check_bit(rd[FLAG_BIT], exp);
        wr_reg(OFS_STATUS, 32'h0, 4'h1);
    endtask : try_hit

    task automatic test_reset;
        logic [31:0] rd;
        rd_reg(OFS_CONTROL, rd);
        check_word(rd, 32'h80);
        rd_reg(OFS_STATUS, rd);
        check_word(rd, 32'h3f);
        rd_reg(OFS_ADDRESS, rd);
        check_word(rd, 32'hffffff);
        rd_reg(3'h6, rd);
        check_word(rd, 32'h0);
        wr_reg(OFS_ADDRESS, {8'h00, TGT}, 4'h7);
        rd_reg(OFS_ADDRESS, rd);
        check_word(rd, {8'h00, TGT});
        check_bit(breakIrq | irqOut | retIrqMask, 1'b0);
    endtask : test_reset

    // every cycle-select code against every access kind
    task automatic test_cycle;
        cycle_kind_t k;
        logic        e;
        for (int s = 0; s < 4; s++) begin
            wr_reg(OFS_CONTROL, 32'h80 | (s << 5), 4'h1);
            for (int j = 1; j < 4; j++) begin
                k = cycle_kind_t'(j);
                e = (s == 0) ? (k == CYC_FETCH) : (s == 3) ? (k != CYC_FETCH)
                    : (j == s + 1);
                try_hit(k, SPACE_RAM, 1'b1, TGT, 16'h0, e);
            end
        end
    endtask : test_cycle

    // low bits just outside the compared field are ignored, inside not
    task automatic test_addr;
        for (int i = 0; i < 4; i++) begin
            wr_reg(OFS_CONTROL, 32'h80 | (i << 2), 4'h1);
            try_hit(CYC_FETCH, SPACE_ROM, 1'b1,
                    TGT | ((24'h1 << (4 * i)) - 1), 16'h0, 1'b1);
            try_hit(CYC_FETCH, SPACE_ROM, 1'b1,
                    TGT ^ (24'h1 << (4 * i)), 16'h0, 1'b0);
        end
        wr_reg(OFS_CONTROL, 32'h90, 4'h1);
        try_hit(CYC_FETCH, SPACE_ROM, 1'b1, TGT, 16'h0, 1'b0);
    endtask : test_addr

    task automatic data_case(input logic [1:0] dc, input space_t s,
                             input logic w, input logic [23:0] a,
                             input logic [15:0] d, input logic exp);
        wr_reg(OFS_CONTROL, {24'h0, 1'b1, SEL_READ, ACMP_12, dc}, 4'h1);
        try_hit(CYC_READ, s, w, a, d, exp);
    endtask : data_case

    // lane choice by space, size and address parity
    task automatic test_data;
        wr_reg(OFS_DATA, 32'ha55a, 4'h3);
        data_case(DCMP_NONE, SPACE_RAM, 1'b1, TGT, 16'h0000, 1'b1);
        data_case(DCMP_HIGH, SPACE_RAM, 1'b0, TGT, 16'ha500, 1'b1);
        data_case(DCMP_HIGH, SPACE_ROM, 1'b0, TGT + 1, 16'ha500, 1'b1);
        data_case(DCMP_HIGH, SPACE_RAM, 1'b0, TGT, 16'h5aa5, 1'b0);
        data_case(DCMP_LOW, SPACE_RAM, 1'b1, TGT + 1, 16'h005a, 1'b1);
        data_case(DCMP_LOW, SPACE_RAM, 1'b1, TGT, 16'h005a, 1'b0);
        data_case(DCMP_HIGH, SPACE_IO16, 1'b1, TGT, 16'ha511, 1'b1);
        data_case(DCMP_LOW, SPACE_IO8, 1'b1, TGT + 1, 16'h005a, 1'b0);
        data_case(DCMP_HIGH, SPACE_IO8, 1'b1, TGT + 1, 16'ha500, 1'b1);
        data_case(DCMP_FULL, SPACE_RAM, 1'b1, TGT, 16'ha55a, 1'b1);
        data_case(DCMP_FULL, SPACE_RAM, 1'b1, TGT, 16'ha55b, 1'b0);
    endtask : test_data

    // a zero write with no prior read of one must not clear the flag
    task automatic test_flag;
        logic [31:0] rd;
        wr_reg(OFS_CONTROL, 32'h80, 4'h1);
        cpu_u.issue(CYC_FETCH, SPACE_ROM, 1'b1, TGT, 16'h0);
        wr_reg(OFS_STATUS, 32'h40, 4'h1);
        repeat (3) @(posedge clk);
        check_bit(breakIrq, 1'b1);
        rd_reg(OFS_STATUS, rd);
        check_word(rd, 32'hff);
        wr_reg(OFS_STATUS, 32'h40, 4'h1);
        repeat (3) @(posedge clk);
        check_bit(breakIrq, 1'b0);
        wr_reg(OFS_STATUS, 32'h00, 4'h1);
        cpu_u.issue(CYC_FETCH, SPACE_ROM, 1'b1, TGT, 16'h0);
        repeat (3) @(posedge clk);
        check_bit(breakIrq, 1'b0);
        try_hit(CYC_IDLE, SPACE_ROM, 1'b1, TGT, 16'h0, 1'b1);
    endtask : test_flag

    // return-from-exception hold-off, interrupt status and mask
    task automatic test_ret;
        logic [31:0] rd;
        wr_reg(OFS_INT_STATUS, 32'h3, 4'h1);
        wr_reg(OFS_CONTROL, 32'h00, 4'h1);
        wr_reg(OFS_STATUS, 32'h40, 4'h1);
        cpu_u.pulse(1'b1);
        repeat (3) @(posedge clk);
        check_bit(retIrqMask, 1'b1);
        cpu_u.issue(CYC_FETCH, SPACE_ROM, 1'b1, TGT, 16'h0);
        repeat (3) @(posedge clk);
        check_bit(breakIrq, 1'b0);
        cpu_u.pulse(1'b0);
        repeat (3) @(posedge clk);
        check_bit(retIrqMask, 1'b0);
        check_bit(breakIrq, 1'b1);
        rd_reg(OFS_INT_STATUS, rd);
        check_word(rd, 32'h3);
        check_bit(irqOut, 1'b0);
        wr_reg(OFS_INT_MASK, 32'h1, 4'h1);
        repeat (3) @(posedge clk);
        check_bit(irqOut, 1'b1);
        wr_reg(OFS_INT_STATUS, 32'h1, 4'h1);
        repeat (3) @(posedge clk);
        check_bit(irqOut, 1'b0);
        wr_reg(OFS_CONTROL, 32'h80, 4'h1);
        cpu_u.pulse(1'b1);
        repeat (3) @(posedge clk);
        check_bit(retIrqMask, 1'b0);
    endtask : test_ret

    // main sequence after an 8-cycle reset
    initial begin
        clk           = 1'b0;
        sys_rst       = 1'b1;
        avsAddress    = 3'h0;
        avsRead       = 1'b0;
        avsWrite      = 1'b0;
        avsWriteData  = 32'h0;
        avsByteEnable = 4'h0;
        failCount     = 0;
        numChecks     = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        test_reset();
        test_cycle();
        test_addr();
        test_data();
        test_flag();
        test_ret();
        final_report();
    end
endmodule : address_break_test
`default_nettype wire

// ### break_match_if.sv
// Purpose: carries break settings and the watched bus cycle to the matcher
// Assumes: one clock, synchronous reset
// Notes:   clk and rst are here only for the matcher's checks
`timescale 1ns/100ps
`default_nettype none
interface break_match_if;
    import address_break_pkg::*;
    logic        clk;
    logic        rst;
    logic [1:0]  cycleSel;
    logic [2:0]  addrSel;
    logic [1:0]  dataSel;
    logic [23:0] matchAddr;
    logic [15:0] matchData;
    cycle_kind_t kind;
    space_t      space;
    logic        wordAccess;
    logic [23:0] busAddr;
    logic [15:0] busData;
    logic        hit;

    modport cfg (output clk, rst, cycleSel, addrSel, dataSel, matchAddr,
                 matchData, kind, space, wordAccess, busAddr, busData,
                 input hit);
    modport cmp (input clk, rst, cycleSel, addrSel, dataSel, matchAddr,
                 matchData, kind, space, wordAccess, busAddr, busData,
                 output hit);
endinterface : break_match_if
`default_nettype wire

// ### break_matcher.sv
// Purpose: decides in one bus cycle whether the break condition holds
// Assumes: bus cycle fields are stable for the cycle they are valid in
// Notes:   purely combinational; the top registers the outcome
`timescale 1ns/100ps
`default_nettype none
module break_matcher (
    // settings and watched cycle
    break_match_if.cmp m
);
    import address_break_pkg::*;

    logic [23:0] addrMask;
    logic        addrOk;
    logic        kindOk;
    logic        lowerLane;
    logic        dataOk;

    // reserved selections keep the mask at zero and force a miss below
    always_comb begin
        case (m.addrSel)
            ACMP_24: addrMask = 24'hffffff;
            ACMP_20: addrMask = 24'hfffff0;
            ACMP_16: addrMask = 24'hffff00;
            ACMP_12: addrMask = 24'hfff000;
            default: addrMask = 24'h000000;
        endcase
    end

    assign addrOk = (m.addrSel[2] == 1'b0)
                  && ((m.busAddr & addrMask) == (m.matchAddr & addrMask));

    // cycle kind filter
    always_comb begin
        case (m.cycleSel)
            SEL_FETCH: kindOk = (m.kind == CYC_FETCH);
            SEL_READ:  kindOk = (m.kind == CYC_READ);
            SEL_WRITE: kindOk = (m.kind == CYC_WRITE);
            default:   kindOk = (m.kind == CYC_READ) || (m.kind == CYC_WRITE);
        endcase
    end

    // lower lane only for odd word access on a 16-bit path; an 8-bit i/o
    // register splits words into two upper-lane bytes
    assign lowerLane = m.wordAccess && m.busAddr[0]
                     && (m.space != SPACE_IO8);

    // byte compares only count when their lane really carries data
    always_comb begin
        case (m.dataSel)
            DCMP_NONE: dataOk = 1'b1;
            DCMP_LOW:  dataOk = lowerLane
                             && (m.busData[7:0] == m.matchData[7:0]);
            DCMP_HIGH: dataOk = !lowerLane
                             && (m.busData[15:8] == m.matchData[15:8]);
            default:   dataOk = (m.busData == m.matchData);
        endcase
    end

    assign m.hit = kindOk && addrOk && dataOk;

    no_reserved_hit_a: assert property (@(posedge m.clk) disable iff (m.rst)
        m.addrSel[2] |-> !m.hit)
        else $error("hit with reserved address compare");
    upper12_match_a: assert property (@(posedge m.clk) disable iff (m.rst)
        (m.hit && m.addrSel == ACMP_12)
            |-> m.busAddr[23:12] == m.matchAddr[23:12])
        else $error("12-bit compare hit on other address");
    fetch_only_a: assert property (@(posedge m.clk) disable iff (m.rst)
        (m.hit && m.cycleSel == SEL_FETCH) |-> m.kind == CYC_FETCH)
        else $error("fetch break hit on data cycle");
    no_data_cmp_a: assert property (@(posedge m.clk) disable iff (m.rst)
        (m.dataSel == DCMP_NONE && m.addrSel == ACMP_24
         && m.kind == CYC_FETCH && m.cycleSel == SEL_FETCH
         && m.busAddr == m.matchAddr) |-> m.hit)
        else $error("address-only break missed");
endmodule : break_matcher
`default_nettype wire

// ### cpu_core_model.sv
// Purpose: cpu core model that launches the watched bus cycles and pulses
// Assumes: one clock; each access lasts one cycle, launched after an edge
// Notes:   idle cycles after an access show inverted address and data, so a stale value
//          can never produce a false match
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
    // clock
    input  wire logic                           clk,
    // watched bus cycle
    output var  address_break_pkg::cycle_kind_t cycleKind,
    output var  address_break_pkg::space_t      space,
    output var  logic                           wordAccess,
    output var  logic [23:0]                    addr,
    output var  logic [15:0]                    data,
    // instruction progress
    output var  logic                           retDone,
    output var  logic                           instrDone
);
    import address_break_pkg::*;

    // quiet bus at time zero
    initial begin
        cycleKind  = CYC_IDLE;
        space      = SPACE_ROM;
        wordAccess = 1'b0;
        addr       = 24'h000000;
        data       = 16'h0000;
        retDone    = 1'b0;
        instrDone  = 1'b0;
    end

    // one access; a fetch carries the first byte address of the opcode
    task automatic issue(input cycle_kind_t k, input space_t s,
                         input logic w, input logic [23:0] a,
                         input logic [15:0] d);
        @(posedge clk);
        cycleKind  <= k;
        space      <= s;
        wordAccess <= w;
        addr       <= a;
        data       <= d;
        @(posedge clk);
        cycleKind  <= CYC_IDLE;
        addr       <= ~a;
        data       <= ~d;
    endtask : issue

    // one-cycle pulse: return-from-exception or instruction completed
    task automatic pulse(input logic isRet);
        @(posedge clk);
        retDone   <= isRet;
        instrDone <= !isRet;
        @(posedge clk);
        retDone   <= 1'b0;
        instrDone <= 1'b0;
    endtask : pulse
endmodule : cpu_core_model
`default_nettype wire
